// *** pesc_defines.svh ***
// Purpose: constants for the phy extended status and counter register bank
// Assumes: apb with 32-bit data, one register per aligned word
// Notes:   register offsets are indices, byte address is four times the index
`ifndef PESC_DEFINES_SVH
`define PESC_DEFINES_SVH

// register indices
`define PESC_IDX_FE_STAT    5'h10
`define PESC_IDX_GB_STAT    5'h11
`define PESC_IDX_BYPASS     5'h12
`define PESC_IDX_RXERR_CNT  5'h13
`define PESC_IDX_FCAR_CNT   5'h14
`define PESC_IDX_LDROP_CNT  5'h15
`define PESC_IDX_PAGE_SEL   5'h1f
`define PESC_PAGE_MAIN      16'h0000

// field positions
`define PESC_BIT_LOCK       15
`define PESC_BIT_LINK       12
`define PESC_BIT_LEGACY     6
`define PESC_BIT_XOVER      5

// fe sticky bits 14,13,11,10,9,8
`define PESC_FE_STICKY_MASK 16'h6f00
// gb sticky bits 14:7
`define PESC_GB_STICKY_MASK 16'h7f80
// bypass writable bits 15:9 and 7:1
`define PESC_BYP_MASK       16'hfefe
`define PESC_BYP_RESET      16'h0088

`define PESC_CNT_MAX        8'hff
`define PESC_CNT_ZERO       8'h00
`define PESC_ZERO16         16'h0000
`define PESC_ZERO32         32'h00000000

`endif

// *** pesc_link_model.sv ***
// Purpose: speed path and link partner status source
// Assumes: events are one-cycle pulses on mclk
// Notes:   levels change only after a rising edge
`timescale 1ns/1ps
module pesc_link_model (
   // clock
   input wire logic             mclk,
   // status toward the bank
   output pesc_pkg::pesc_live_t fe_live,
   output pesc_pkg::pesc_live_t gb_live,
   output pesc_pkg::pesc_evt_t  fe_evt,
   output pesc_pkg::pesc_evt_t  gb_evt,
   output logic                 ten_link_drop,
   output logic                 legacy_seen,
   output logic                 xover_err
);
   initial begin
      {fe_live, gb_live, fe_evt, gb_evt} = '0;
      {ten_link_drop, legacy_seen, xover_err} = '0;
   end
   task set_live(input logic [1:0] f, g, input logic l, x);
      @(posedge mclk);
      {fe_live, gb_live, legacy_seen, xover_err} <= {f, g, l, x};
   endtask
   // one event pulse, then a quiet cycle
   task pulse(input logic g, input logic [7:0] e, input logic t);
      @(posedge mclk);
      {fe_evt, gb_evt, ten_link_drop} <= g ? {8'h00, e, t} : {e, 8'h00, t};
      @(posedge mclk);
      {fe_evt, gb_evt, ten_link_drop} <= '0;
   endtask
endmodule // pesc_link_model

// *** pesc_pkg.sv ***
// Purpose: types for the phy extended status and counter register bank
// Assumes: constants come from pesc_defines.svh
// Notes:   all state of the bank is one packed struct
package pesc_pkg;

   // event pulses from one speed path
   typedef struct packed {
      logic lock_err;
      logic disconnect;
      logic rx_err;
      logic tx_err;
      logic sof_err;
      logic eof_err;
      logic cext_err;
      logic false_car;
   } pesc_evt_t;

   // live levels from one speed path
   typedef struct packed {
      logic locked;
      logic link_up;
   } pesc_live_t;

   // bypass and disable controls toward the datapath
   typedef struct packed {
      logic tx_out_off;
      logic byp_4b5b;
      logic byp_scram;
      logic byp_descram;
      logic byp_pcs_rx;
      logic byp_pcs_tx;
      logic byp_lfi_timer;
      logic no_auto_xover_forced;
      logic legacy_detect_off;
      logic no_xover_correct;
      logic no_polarity_correct;
      logic honour_adv_ability;
      logic pulse_shape_off;
      logic np_exchange_off;
   } pesc_ctl_t;

   typedef struct packed {
      logic [15:0] fe_sticky;
      logic [15:0] gb_sticky;
      logic [15:0] bypass;
      logic [15:0] page;
      logic [7:0]  rxerr_cnt;
      logic [7:0]  fcar_cnt;
      logic [7:0]  ldrop_cnt;
      logic [31:0] prdata;
   } pesc_state_t;

endpackage

// *** pesc_regs.sv ***
// Purpose: apb register bank for phy extended status, bypass and counters
// Assumes: status inputs come from logic on mclk
// Notes:   page select register chooses the page the bank answers on
//
// Function
// - six 16-bit registers on page 0 at indices 16 to 21 in order
// - fast status bits 15 and 12 show live lock and link
// - fast status bits 14,13,11:8 latch errors and clear when read
// - gigabit status bits 15 and 12 show live lock and link
// - gigabit status bits 14,13,11:7 latch errors and clear when read
// - gigabit bits 6 and 5 show legacy partner and crossover error, no self-clear
// - bypass bit 15 stops transmitter output to media, resets zero
// - bypass bits 14:9 bypass coder, scramblers, pcs paths, link timer
// - bypass bit 7 disables auto crossover in forced 10/100, resets one
// - bypass bits 5 and 4 disable crossover and polarity correction
// - bypass bit 6 disables legacy gigabit partner detection
// - bypass bit 3 one honours advertised abilities, resets one
// - bypass bit 2 removes gigabit pulse shaping filter
// - bypass bit 1 suppresses automatic gigabit next-page exchange
// - shared receive error counter counts only while that link is up
// - shared false carrier counter counts only while that link is up
// - link drop counter counts drops at any speed, drops in the same cycle count once
// - counters saturate at 255, clear on read, reset to zero
`timescale 1ns/1ps
`include "pesc_defines.svh"

module pesc_regs (
   // clock and reset
   input  wire logic              mclk,
   input  wire logic              rst,
   // apb slave
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [31:0]       paddr,
   input  wire logic [31:0]       pwdata,
   input  wire logic [3:0]        pstrb,
   output logic      [31:0]       prdata,
   output logic                   pready,
   output logic                   pslverr,
   // status from the speed paths
   input  wire pesc_pkg::pesc_live_t fe_live,
   input  wire pesc_pkg::pesc_live_t gb_live,
   input  wire pesc_pkg::pesc_evt_t  fe_evt,
   input  wire pesc_pkg::pesc_evt_t  gb_evt,
   input  wire logic              ten_link_drop,
   input  wire logic              legacy_seen,
   input  wire logic              xover_err,
   // controls to the datapath
   output pesc_pkg::pesc_ctl_t    ctl
);

   pesc_pkg::pesc_state_t s_q;
   pesc_pkg::pesc_state_t s_d;

   logic        acc;
   logic        rd;
   logic        wr;
   logic        page0;
   logic        hit;
   logic        mapped;
   logic [4:0]  idx;
   logic [15:0] fe_set;
   logic [15:0] gb_set;
   logic [15:0] fe_view;
   logic [15:0] gb_view;
   logic [15:0] rdata;
   logic        inc_rx;
   logic        inc_fc;
   logic        inc_ld;

   ////////////////////////////////////////////////////////////////////////////
   // counter update: a read takes away only what it returned, later events stay
   function automatic logic [7:0] cnt_next(input logic [7:0] c, input logic inc,
                                           input logic clr, input logic [7:0] sub);
      logic [7:0] r;
      r = clr ? (c - sub) : c;
      if (inc && (r != `PESC_CNT_MAX)) begin
         r = r + 8'h01;
      end
      return r;
   endfunction

   // 16-bit write with byte strobes
   function automatic logic [15:0] strb_merge(input logic [15:0] old,
                                              input logic [31:0] wd,
                                              input logic [3:0] st);
      logic [15:0] r;
      r = old;
      if (st[0]) begin
         r[7:0] = wd[7:0];
      end
      if (st[1]) begin
         r[15:8] = wd[15:8];
      end
      return r;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // decode
   assign idx    = paddr[6:2];
   assign acc    = psel && penable;
   assign page0  = (s_q.page == `PESC_PAGE_MAIN);
   assign hit    = (paddr[31:7] == 25'h0000000) && (paddr[1:0] == 2'h0);
   assign rd     = acc && !pwrite && hit && page0;
   assign wr     = acc && pwrite && hit;
   assign pready = 1'b1;

   always_comb begin
      mapped = 1'b0;
      if (hit && (idx == `PESC_IDX_PAGE_SEL)) begin
         mapped = 1'b1;
      end else if (hit && page0 && (idx >= `PESC_IDX_FE_STAT)
                   && (idx <= `PESC_IDX_LDROP_CNT)) begin
         mapped = 1'b1;
      end
   end
   assign pslverr = acc && !mapped;

   ////////////////////////////////////////////////////////////////////////////
   // status views
   always_comb begin
      fe_set = `PESC_ZERO16;
      fe_set[14] = fe_evt.lock_err;
      fe_set[13] = fe_evt.disconnect;
      fe_set[11] = fe_evt.rx_err;
      fe_set[10] = fe_evt.tx_err;
      fe_set[9]  = fe_evt.sof_err;
      fe_set[8]  = fe_evt.eof_err;
      gb_set = `PESC_ZERO16;
      gb_set[14] = gb_evt.lock_err;
      gb_set[13] = gb_evt.disconnect;
      gb_set[11] = gb_evt.rx_err;
      gb_set[10] = gb_evt.tx_err;
      gb_set[9]  = gb_evt.sof_err;
      gb_set[8]  = gb_evt.eof_err;
      gb_set[7]  = gb_evt.cext_err;
      fe_view = s_q.fe_sticky & `PESC_FE_STICKY_MASK;
      fe_view[`PESC_BIT_LOCK] = fe_live.locked;
      fe_view[`PESC_BIT_LINK] = fe_live.link_up;
      gb_view = s_q.gb_sticky & `PESC_GB_STICKY_MASK;
      gb_view[`PESC_BIT_LOCK]   = gb_live.locked;
      gb_view[`PESC_BIT_LINK]   = gb_live.link_up;
      gb_view[`PESC_BIT_LEGACY] = legacy_seen && !s_q.bypass[6];
      gb_view[`PESC_BIT_XOVER]  = xover_err;
   end

   // counter events
   assign inc_rx = (fe_evt.rx_err && fe_live.link_up)
                 || (gb_evt.rx_err && gb_live.link_up);
   assign inc_fc = (fe_evt.false_car && fe_live.link_up)
                 || (gb_evt.false_car && gb_live.link_up);
   assign inc_ld = fe_evt.disconnect || gb_evt.disconnect || ten_link_drop;

   always_comb begin
      rdata = `PESC_ZERO16;
      case (idx)
         `PESC_IDX_FE_STAT:   rdata = fe_view;
         `PESC_IDX_GB_STAT:   rdata = gb_view;
         `PESC_IDX_BYPASS:    rdata = s_q.bypass & `PESC_BYP_MASK;
         `PESC_IDX_RXERR_CNT: rdata = {8'h00, s_q.rxerr_cnt};
         `PESC_IDX_FCAR_CNT:  rdata = {8'h00, s_q.fcar_cnt};
         `PESC_IDX_LDROP_CNT: rdata = {8'h00, s_q.ldrop_cnt};
         default:             rdata = `PESC_ZERO16;
      endcase
      if (hit && (idx == `PESC_IDX_PAGE_SEL)) begin
         rdata = s_q.page;
      end else if (!page0) begin
         rdata = `PESC_ZERO16;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // next state
   always_comb begin
      s_d = s_q;
      // sticky: the read clears only the bits it returned, set wins
      if (rd && (idx == `PESC_IDX_FE_STAT)) begin
         s_d.fe_sticky = s_q.fe_sticky & ~(s_q.prdata[15:0] & `PESC_FE_STICKY_MASK);
      end
      s_d.fe_sticky = s_d.fe_sticky | fe_set;
      if (rd && (idx == `PESC_IDX_GB_STAT)) begin
         s_d.gb_sticky = s_q.gb_sticky & ~(s_q.prdata[15:0] & `PESC_GB_STICKY_MASK);
      end
      s_d.gb_sticky = s_d.gb_sticky | gb_set;
      s_d.rxerr_cnt = cnt_next(s_q.rxerr_cnt, inc_rx,
                               rd && (idx == `PESC_IDX_RXERR_CNT),
                               s_q.prdata[7:0]);
      s_d.fcar_cnt  = cnt_next(s_q.fcar_cnt, inc_fc,
                               rd && (idx == `PESC_IDX_FCAR_CNT),
                               s_q.prdata[7:0]);
      s_d.ldrop_cnt = cnt_next(s_q.ldrop_cnt, inc_ld,
                               rd && (idx == `PESC_IDX_LDROP_CNT),
                               s_q.prdata[7:0]);
      if (wr && page0 && (idx == `PESC_IDX_BYPASS)) begin
         s_d.bypass = strb_merge(s_q.bypass, pwdata, pstrb) & `PESC_BYP_MASK;
      end
      if (wr && (idx == `PESC_IDX_PAGE_SEL)) begin
         s_d.page = strb_merge(s_q.page, pwdata, pstrb);
      end
      // read data captured in the setup cycle so it stands at the access edge
      if (psel && !penable && !pwrite) begin
         s_d.prdata = {16'h0000, rdata};
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         s_q.fe_sticky <= `PESC_ZERO16;
         s_q.gb_sticky <= `PESC_ZERO16;
         s_q.bypass    <= `PESC_BYP_RESET;
         s_q.page      <= `PESC_PAGE_MAIN;
         s_q.rxerr_cnt <= `PESC_CNT_ZERO;
         s_q.fcar_cnt  <= `PESC_CNT_ZERO;
         s_q.ldrop_cnt <= `PESC_CNT_ZERO;
         s_q.prdata    <= `PESC_ZERO32;
      end else begin
         s_q <= s_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // outputs
   assign prdata = s_q.prdata;

   always_comb begin
      ctl.tx_out_off           = s_q.bypass[15];
      ctl.byp_4b5b             = s_q.bypass[14];
      ctl.byp_scram            = s_q.bypass[13];
      ctl.byp_descram          = s_q.bypass[12];
      ctl.byp_pcs_rx           = s_q.bypass[11];
      ctl.byp_pcs_tx           = s_q.bypass[10];
      ctl.byp_lfi_timer        = s_q.bypass[9];
      ctl.no_auto_xover_forced = s_q.bypass[7];
      ctl.legacy_detect_off    = s_q.bypass[6];
      ctl.no_xover_correct     = s_q.bypass[5];
      ctl.no_polarity_correct  = s_q.bypass[4];
      ctl.honour_adv_ability   = s_q.bypass[3];
      ctl.pulse_shape_off      = s_q.bypass[2];
      ctl.np_exchange_off      = s_q.bypass[1];
   end

endmodule // pesc_regs

// *** pesc_regs_properties.sv ***
// Purpose: assertions on the register bank ports
// Assumes: zero-wait apb, read data registered in the setup cycle
// Notes:   bound to pesc_regs
`timescale 1ns/1ps
module pesc_regs_props (
   // clock and reset
   input wire logic                 mclk,
   input wire logic                 rst,
   // apb
   input wire logic                 psel,
   input wire logic                 penable,
   input wire logic                 pwrite,
   input wire logic [31:0]          paddr,
   input wire logic [31:0]          pwdata,
   input wire logic [3:0]           pstrb,
   input wire logic [31:0]          prdata,
   input wire logic                 pready,
   input wire logic                 pslverr,
   // status and controls
   input wire pesc_pkg::pesc_live_t fe_live,
   input wire pesc_pkg::pesc_live_t gb_live,
   input wire pesc_pkg::pesc_evt_t  fe_evt,
   input wire logic                 xover_err,
   input wire pesc_pkg::pesc_ctl_t  ctl
);
   default clocking @(posedge mclk); endclocking
   default disable iff (rst);
   logic acc, rd, wr, su;
   assign acc = psel && penable;
   assign su = psel && !penable && !pwrite;
   assign rd = acc && !pwrite;
   assign wr = acc && pwrite && paddr == 32'h48;
   ////////////////////////////////////////////////////////////////////////
   property p_map; acc && paddr > 32'h7f |-> pslverr && pready; endproperty
   a_map: assert property (p_map) else $error("unmapped access not refused");
   property p_tx; wr && pstrb[1] |=> ctl.tx_out_off == $past(pwdata[15]); endproperty
   a_tx: assert property (p_tx) else $error("transmit off control wrong");
   property p_xo7; wr && pstrb[0] |=> ctl.no_auto_xover_forced == $past(pwdata[7]); endproperty
   a_xo7: assert property (p_xo7) else $error("forced crossover control wrong");
   property p_adv; wr && pstrb[0] |=> ctl.honour_adv_ability == $past(pwdata[3]); endproperty
   a_adv: assert property (p_adv) else $error("advertised ability control wrong");
   property p_fe; su && paddr == 32'h40 |=> prdata[15] == $past(fe_live.locked)
      && prdata[12] == $past(fe_live.link_up); endproperty
   a_fe: assert property (p_fe) else $error("fast live bits wrong");
   property p_gb; su && paddr == 32'h44 |=> prdata[15] == $past(gb_live.locked)
      && prdata[12] == $past(gb_live.link_up); endproperty
   a_gb: assert property (p_gb) else $error("gigabit live bits wrong");
   property p_xe; su && paddr == 32'h44 |=> prdata[5] == $past(xover_err); endproperty
   a_xe: assert property (p_xe) else $error("crossover error bit wrong");
   property p_stk; fe_evt.rx_err ##2 su && paddr == 32'h40 |=> prdata[11]; endproperty
   a_stk: assert property (p_stk) else $error("receive error flag not latched");
   property p_hi; rd && paddr inside {32'h4c, 32'h50, 32'h54} |=> prdata[31:8] == 24'h0;
   endproperty
   a_hi: assert property (p_hi) else $error("counter upper bits not zero");
endmodule // pesc_regs_props
bind pesc_regs pesc_regs_props u_props (.mclk, .rst, .psel, .penable, .pwrite, .paddr,
   .pwdata, .pstrb, .prdata, .pready, .pslverr, .fe_live, .gb_live, .fe_evt, .xover_err, .ctl);

// *** testbench.sv ***
// Purpose: self-checking bench for the register bank
// Assumes: zero-wait apb, read data taken at the access edge
// Notes:   the link model drives all status inputs
`timescale 1ns/1ps
`define CHK(n, e, a) begin tests_run++; if ((a) !== (e)) begin err_count++; \
   $display("CHECK FAILED %s exp %h got %h", n, e, a); end end
module testbench;
   logic                 mclk = 1'b0;
   logic                 rst = 1'b1;
   logic                 psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, se;
   logic [31:0]          paddr = '0, pwdata = '0, prdata, d;
   logic [3:0]           pstrb = 4'hf;
   pesc_pkg::pesc_live_t fe_live, gb_live;
   pesc_pkg::pesc_evt_t  fe_evt, gb_evt;
   pesc_pkg::pesc_ctl_t  ctl;
   logic                 ten_link_drop, legacy_seen, xover_err;
   int                   err_count = 0, tests_run = 0, cyc = 0;
   always #5 mclk = ~mclk;
   pesc_link_model u_far (.mclk, .fe_live, .gb_live, .fe_evt, .gb_evt, .ten_link_drop,
      .legacy_seen, .xover_err);
   pesc_regs u_dut (.mclk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata,
      .pready, .pslverr, .fe_live, .gb_live, .fe_evt, .gb_evt, .ten_link_drop, .legacy_seen,
      .xover_err, .ctl);
   task results;
      $display("checks %0d mismatches %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 20000) begin
         err_count++;
         results();
      end
   end
   ////////////////////////////////////////////////////////////////////////
   // one apb transfer; ev pulses a fast receive error in the access cycle
   task apb(input logic w, input logic [31:0] a, wd, input logic [3:0] s, input logic ev);
      @(posedge mclk);
      {psel, pwrite, paddr, pwdata, pstrb} <= {1'b1, w, a, wd, s};
      @(posedge mclk);
      penable <= 1'b1;
      u_far.fe_evt.rx_err <= ev;
      do @(posedge mclk); while (pready !== 1'b1);
      se = pslverr;
      {psel, penable} <= 2'b00;
      u_far.fe_evt.rx_err <= 1'b0;
      d = prdata;
   endtask
   task rd(input logic [31:0] a, e);
      apb(1'b0, a, '0, 4'hf, 1'b0);
      `CHK("read", e, d)
   endtask
   ////////////////////////////////////////////////////////////////////////
   task t_reset;
      for (int i = 0; i < 6; i++) rd(32'h40 + 4 * i, (i == 2) ? 32'h88 : 32'h0);
      `CHK("ctl", 14'h0044, ctl)
   endtask
   task t_bypass;
      apb(1'b1, 32'h48, 32'hffffffff, 4'h1, 1'b0);
      rd(32'h48, 32'h00fe);
      apb(1'b1, 32'h48, 32'hffffffff, 4'hf, 1'b0);
      rd(32'h48, 32'hfefe);
      @(posedge mclk);
      `CHK("ctl", 14'h3fff, ctl)
      apb(1'b1, 32'h48, 32'h0, 4'hf, 1'b0);
      @(posedge mclk);
      `CHK("ctl", 14'h0000, ctl)
   endtask
   task t_sticky;
      u_far.set_live(2'b11, 2'b11, 1'b1, 1'b1);
      u_far.pulse(1'b0, 8'hff, 1'b0);
      u_far.pulse(1'b1, 8'hff, 1'b0);
      rd(32'h40, 32'hff00);
      rd(32'h40, 32'h9000);
      rd(32'h44, 32'hffe0);
      rd(32'h44, 32'h9060);
   endtask
   task t_count;
      rd(32'h4c, 32'h2);
      rd(32'h50, 32'h2);
      rd(32'h54, 32'h2);
      u_far.set_live(2'b11, 2'b00, 1'b0, 1'b0);
      repeat (3) u_far.pulse(1'b0, 8'h20, 1'b0);
      u_far.pulse(1'b1, 8'h21, 1'b0);
      rd(32'h4c, 32'h3);
      rd(32'h50, 32'h0);
      repeat (260) u_far.pulse(1'b0, 8'h01, 1'b0);
      rd(32'h50, 32'hff);
      rd(32'h50, 32'h0);
      u_far.pulse(1'b0, 8'h40, 1'b0);
      u_far.pulse(1'b0, 8'h00, 1'b1);
      u_far.pulse(1'b1, 8'h40, 1'b0);
      rd(32'h54, 32'h3);
      apb(1'b0, 32'h4c, '0, 4'hf, 1'b1);
      `CHK("read", 32'h0, d)
      rd(32'h4c, 32'h1);
   endtask
   task t_unmapped;
      apb(1'b1, 32'h100, 32'hffff, 4'hf, 1'b0);
      `CHK("slverr", 1'b1, se)
      rd(32'h100, 32'h0);
      `CHK("slverr", 1'b1, se)
      rd(32'h48, 32'h0);
   endtask
   initial begin
      repeat (3) @(posedge mclk);
      rst <= 1'b0;
      t_reset();
      t_bypass();
      t_sticky();
      t_count();
      t_unmapped();
      results();
   end
endmodule // testbench
